// File: irq_poll_pkg.sv
// Purpose: Shared constants for the poll / end-of-interrupt / vector block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Printed offsets are not all multiples of four, so they are indices
package irq_poll_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_SRC = 32;
	localparam int unsigned NUM_LVL = 8;
	// Register indices as printed; byte address is four times the index
	localparam logic [7:0] IDX_VECTOR_BASE = 8'h20;
	localparam logic [7:0] IDX_EOI = 8'h22;
	localparam logic [7:0] IDX_POLL_ACK = 8'h24;
	localparam logic [7:0] IDX_POLL_PEEK = 8'h26;
	localparam logic [7:0] IDX_IN_SERVICE = 8'h2C;
	localparam logic [7:0] IDX_MODE = 8'h30;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h31;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h32;
	// Field positions
	localparam int unsigned PENDING_BIT = 15;
	localparam int unsigned NONSPEC_BIT = 15;
	localparam int unsigned TYPE_W = 5;
	localparam int unsigned LEVEL_W = 3;
	localparam int unsigned VEC_LSB = 3;
	localparam int unsigned VEC_MSB = 7;
	// Event bits of the status register
	localparam int unsigned EV_ACK = 0;
	localparam int unsigned EV_EOI = 1;
	localparam int unsigned EV_PEND = 2;
	localparam int unsigned EV_W = 3;
	// Reset values
	localparam logic [31:0] IN_SERVICE_RST = 32'h0000_0000;
	localparam logic [4:0] VECTOR_RST = 5'h00;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRESP = 2'b01,
		BUS_RRESP = 2'b10
	} bus_state_t;
endpackage

// File: in_service_store.sv
// Purpose: In-service bit store with set-on-take and clear-on-end
// Assumes: At most one take and one clear per cycle
// Notes:   A take wins over a clear of the same bit
`timescale 1ns/1ps
module in_service_store (
	// Clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst_b,
	// Updates
	input  wire logic [irq_poll_pkg::NUM_SRC-1:0]   set_vec,
	input  wire logic [irq_poll_pkg::NUM_SRC-1:0]   clr_vec,
	// State
	output logic      [irq_poll_pkg::NUM_SRC-1:0]   bits_q
);
	import irq_poll_pkg::*;
	logic [NUM_SRC-1:0] bits_d;

	always_comb begin
		bits_d = (bits_q & ~clr_vec) | set_vec;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			bits_q <= IN_SERVICE_RST;
		end else begin
			bits_q <= bits_d;
		end
	end
endmodule

// File: irq_poll_eoi_vector.sv
// Purpose: Poll, end-of-interrupt and vector-base logic of an interrupt controller
// Assumes: AXI4-Lite slave, requests synchronous to sys_clk
// Notes:   Master mode uses 32 typed sources; slave mode uses 8 priority levels
//          Vector, mode and in-service reset to zero; the end command keeps no value
//          A non-specific clear with nothing in service is ignored
`timescale 1ns/1ps
module irq_poll_eoi_vector (
	// Clock and reset
	input  wire logic                                sys_clk,
	input  wire logic                                rst_b,
	// Interrupt sources (index = type, or level in slave mode)
	input  wire logic [irq_poll_pkg::NUM_SRC-1:0]    irq_request,
	// AXI4-Lite write address
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	input  wire logic [irq_poll_pkg::ADDR_W+1:0]     s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	input  wire logic [irq_poll_pkg::DATA_W-1:0]     s_axi_wdata,
	input  wire logic [3:0]                          s_axi_wstrb,
	// AXI4-Lite write response
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	output logic      [1:0]                          s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	input  wire logic [irq_poll_pkg::ADDR_W+1:0]     s_axi_araddr,
	// AXI4-Lite read data
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	output logic      [irq_poll_pkg::DATA_W-1:0]     s_axi_rdata,
	output logic      [1:0]                          s_axi_rresp,
	// Interrupt to the core
	output logic                                     irq_out
);
	import irq_poll_pkg::*;

	// Bus state
	bus_state_t         wst_q, wst_d, rst_q, rst_d;
	logic               aw_have_q, aw_have_d, w_have_q, w_have_d;
	logic [ADDR_W-1:0]  waddr_q, waddr_d;
	logic [DATA_W-1:0]  wdata_q, wdata_d;
	logic [3:0]         wstrb_q, wstrb_d;
	logic               bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [1:0]         bresp_q, bresp_d, rresp_q, rresp_d;
	logic [DATA_W-1:0]  rdata_q, rdata_d;
	logic               awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
	// Control state
	logic               slave_mode_q, slave_mode_d;
	logic [4:0]         vec_upper_q, vec_upper_d;
	logic [EV_W-1:0]    irq_status_q, irq_status_d;
	logic [EV_W-1:0]    irq_mask_q, irq_mask_d;
	logic               irq_q, irq_d;
	logic               pend_q;
	// In-service store
	logic [NUM_SRC-1:0] in_service;
	logic [NUM_SRC-1:0] is_set, is_clr;
	logic               take_ack;
	logic               eoi_hit;
	logic               eoi_nonspec;
	logic [TYPE_W-1:0]  eoi_target;
	// Poll evaluation
	logic [NUM_SRC-1:0] eligible;
	logic               pending;
	logic [TYPE_W-1:0]  top_type;
	logic [TYPE_W-1:0]  top_service;
	logic               any_service;
	logic [15:0]        poll_word;
	logic               do_write, do_read;
	logic [ADDR_W-1:0]  rindex;
	logic [EV_W-1:0]    events;

	in_service_store i_in_service_store (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.set_vec (is_set),
		.clr_vec (is_clr),
		.bits_q  (in_service)
	);

	// Slave mode counts only the eight level lines
	for (genvar k = 0; k < NUM_SRC; k++) begin : g_elig
		if (k < NUM_LVL) begin : g_lvl
			assign eligible[k] = irq_request[k] && !in_service[k];
		end else begin : g_src
			assign eligible[k] = irq_request[k] && !in_service[k] && !slave_mode_q;
		end
	end

	// Lowest index wins
	always_comb begin
		pending = 1'b0;
		top_type = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (eligible[i]) begin
				pending = 1'b1;
				top_type = TYPE_W'(i);
			end
		end
		any_service = 1'b0;
		top_service = '0;
		for (int j = NUM_SRC - 1; j >= 0; j--) begin
			if (in_service[j]) begin
				any_service = 1'b1;
				top_service = TYPE_W'(j);
			end
		end
		// Type field valid only with the pending flag; reserved bits zero
		poll_word = 16'h0000;
		poll_word[PENDING_BIT] = pending;
		poll_word[PENDING_BIT-1:TYPE_W] = '0;
		if (pending) begin
			poll_word[TYPE_W-1:0] = top_type;
		end
	end

	assign do_write = aw_have_q && w_have_q && (wst_q == BUS_IDLE);
	assign do_read  = s_axi_arvalid && arready_q;
	assign rindex   = s_axi_araddr[ADDR_W+1:2];

	// In-service updates: take on acknowledging poll, clear on end-of-interrupt
	always_comb begin
		take_ack = do_read && rindex == IDX_POLL_ACK && pending;
		eoi_hit = do_write && waddr_q == IDX_EOI && wstrb_q[0];
		eoi_nonspec = 1'b0;
		eoi_target = wdata_q[TYPE_W-1:0];
		if (slave_mode_q) begin
			eoi_target = TYPE_W'(wdata_q[LEVEL_W-1:0]);
		end else if (wstrb_q[1] && wdata_q[NONSPEC_BIT]) begin
			eoi_nonspec = 1'b1;
			eoi_target = top_service;
		end
	end

	// An empty non-specific clear must not fall back on source zero
	for (genvar k = 0; k < NUM_SRC; k++) begin : g_strobe
		assign is_set[k] = take_ack && top_type == TYPE_W'(k);
		assign is_clr[k] = eoi_hit && eoi_target == TYPE_W'(k) && (any_service || !eoi_nonspec);
	end

	// Write channel
	// Address and data arrive in either order; the write acts once both are held
	always_comb begin
		wst_d = wst_q;
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		awready_d = awready_q;
		wready_d = wready_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		slave_mode_d = slave_mode_q;
		vec_upper_d = vec_upper_q;
		irq_mask_d = irq_mask_q;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			waddr_d = s_axi_awaddr[ADDR_W+1:2];
			awready_d = 1'b0;
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
			wready_d = 1'b0;
		end
		case (wst_q)
			BUS_IDLE: begin
				if (do_write) begin
					bresp_d = RESP_OKAY;
					case (waddr_q)
						IDX_EOI: ;
						IDX_VECTOR_BASE: begin
							if (wstrb_q[0]) begin
								vec_upper_d = wdata_q[VEC_MSB:VEC_LSB];
							end
						end
						IDX_MODE: begin
							if (wstrb_q[0]) begin
								slave_mode_d = wdata_q[0];
							end
						end
						IDX_IRQ_MASK: begin
							if (wstrb_q[0]) begin
								irq_mask_d = wdata_q[EV_W-1:0];
							end
						end
						// Poll and status registers take no writes
						IDX_POLL_ACK, IDX_POLL_PEEK: bresp_d = RESP_SLVERR;
						default: bresp_d = RESP_SLVERR;
					endcase
					bvalid_d = 1'b1;
					wst_d = BUS_WRESP;
				end
			end
			BUS_WRESP: begin
				if (s_axi_bready) begin
					bvalid_d = 1'b0;
					aw_have_d = 1'b0;
					w_have_d = 1'b0;
					awready_d = 1'b1;
					wready_d = 1'b1;
					wst_d = BUS_IDLE;
				end
			end
			default: wst_d = BUS_IDLE;
		endcase
	end

	// Read channel
	// The acknowledging read takes on its accept edge, so its data show the state before
	always_comb begin
		rst_d = rst_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rst_q)
			BUS_IDLE: begin
				if (do_read) begin
					arready_d = 1'b0;
					rvalid_d = 1'b1;
					rresp_d = RESP_OKAY;
					rdata_d = '0;
					case (rindex)
						IDX_POLL_PEEK: rdata_d[15:0] = poll_word;
						IDX_POLL_ACK: rdata_d[15:0] = poll_word;
						IDX_VECTOR_BASE: rdata_d[VEC_MSB:VEC_LSB] = vec_upper_q;
						IDX_IN_SERVICE: rdata_d = in_service;
						IDX_MODE: rdata_d[0] = slave_mode_q;
						IDX_IRQ_STATUS: rdata_d[EV_W-1:0] = irq_status_q;
						IDX_IRQ_MASK: rdata_d[EV_W-1:0] = irq_mask_q;
						// End-of-interrupt is write-only
						IDX_EOI: rdata_d = '0;
						default: rresp_d = RESP_SLVERR;
					endcase
					rst_d = BUS_RRESP;
				end
			end
			BUS_RRESP: begin
				if (s_axi_rready) begin
					rvalid_d = 1'b0;
					arready_d = 1'b1;
					rst_d = BUS_IDLE;
				end
			end
			default: rst_d = BUS_IDLE;
		endcase
	end

	// Sticky events; a new event wins over the read that clears them
	always_comb begin
		events = '0;
		events[EV_ACK] = |is_set;
		events[EV_EOI] = |is_clr;
		events[EV_PEND] = pending && !pend_q;
		irq_status_d = irq_status_q;
		if (do_read && rindex == IDX_IRQ_STATUS) begin
			irq_status_d = '0;
		end
		irq_status_d = irq_status_d | events;
		irq_d = |(irq_status_d & irq_mask_q);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wst_q <= BUS_IDLE;
			rst_q <= BUS_IDLE;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			arready_q <= 1'b1;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rresp_q <= RESP_OKAY;
			rdata_q <= '0;
			slave_mode_q <= 1'b0;
			vec_upper_q <= VECTOR_RST;
			irq_status_q <= '0;
			irq_mask_q <= IRQ_MASK_RST;
			irq_q <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			wst_q <= wst_d;
			rst_q <= rst_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			arready_q <= arready_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			bresp_q <= bresp_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
			slave_mode_q <= slave_mode_d;
			vec_upper_q <= vec_upper_d;
			irq_status_q <= irq_status_d;
			irq_mask_q <= irq_mask_d;
			irq_q <= irq_d;
			pend_q <= pending;
		end
	end

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_arready = arready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign irq_out       = irq_q;
endmodule

// File: irq_poll_eoi_vector_properties.sv
// Purpose: Bus-level properties of the poll and end-of-interrupt block
// Assumes: Write address and data offered together
// Notes:   Last read address kept to qualify read data
`timescale 1ns/1ps
module irq_poll_eoi_vector_properties (
	// Clock and reset
	input wire logic                             sys_clk,
	input wire logic                             rst_b,
	// Sources
	input wire logic [irq_poll_pkg::NUM_SRC-1:0] irq_request,
	// Write side
	input wire logic                             s_axi_awvalid,
	input wire logic                             s_axi_awready,
	input wire logic [irq_poll_pkg::ADDR_W+1:0]  s_axi_awaddr,
	input wire logic                             s_axi_wvalid,
	input wire logic                             s_axi_wready,
	input wire logic                             s_axi_bvalid,
	input wire logic [1:0]                       s_axi_bresp,
	// Read side
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic [irq_poll_pkg::ADDR_W+1:0]  s_axi_araddr,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	input wire logic [irq_poll_pkg::DATA_W-1:0]  s_axi_rdata
);
	import irq_poll_pkg::*;
	logic [ADDR_W+1:0] ra_d;
	logic [ADDR_W+1:0] ra_q;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	always_comb begin
		ra_d = s_axi_arvalid && s_axi_arready ? s_axi_araddr : ra_q;
	end
	always_ff @(posedge sys_clk) begin
		ra_q <= ra_d;
	end
	property p_rd_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	property p_rd_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_idle_poll;
		s_axi_arvalid && s_axi_arready && s_axi_araddr[9:4] == 6'h09 && irq_request == 32'h0 |=> !s_axi_rdata[15];
	endproperty
	a_idle_poll: assert property (p_idle_poll) else $error("pending flag without request");
	property p_poll_rsvd;
		s_axi_rvalid && ra_q[9:4] == 6'h09 |-> s_axi_rdata[14:5] == 10'h000 && s_axi_rdata[31:16] == 16'h0000;
	endproperty
	a_poll_rsvd: assert property (p_poll_rsvd) else $error("poll reserved bits set");
	property p_vec_rsvd;
		s_axi_rvalid && ra_q == 10'h080 |-> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[2:0] == 3'h0;
	endproperty
	a_vec_rsvd: assert property (p_vec_rsvd) else $error("vector reserved bits set");
	property p_eoi_noread;
		s_axi_rvalid && ra_q == 10'h088 |-> s_axi_rdata == 32'h0;
	endproperty
	a_eoi_noread: assert property (p_eoi_noread) else $error("end command readable");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	property p_poll_ro;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_awaddr[9:4] == 6'h09
			|-> ##2 s_axi_bvalid && s_axi_bresp == RESP_SLVERR;
	endproperty
	a_poll_ro: assert property (p_poll_ro) else $error("poll write accepted");
endmodule
bind irq_poll_eoi_vector irq_poll_eoi_vector_properties i_irq_poll_eoi_vector_properties (.sys_clk, .rst_b,
	.irq_request, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

// File: irq_source_model.sv
// Purpose: Interrupt sources holding level requests
// Assumes: A line stays up until its source is serviced
// Notes:   Raise wins over drop in one cycle
`timescale 1ns/1ps
module irq_source_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// Bench control
	input  wire logic [31:0] raise,
	input  wire logic [31:0] drop,
	// Request lines
	output logic      [31:0] irq_request
);
	logic [31:0] req_d;
	logic [31:0] req_q;
	always_comb begin
		req_d = (req_q & ~drop) | raise;
	end
	always_ff @(posedge sys_clk) begin
		req_q <= rst_b ? req_d : 32'h0;
	end
	assign irq_request = req_q;
endmodule

// File: irq_poll_eoi_vector_tb_top.sv
// Purpose: Register-level test of the poll, end-of-interrupt and vector block
// Assumes: One AXI4-Lite transfer at a time
// Notes:   Requests come from the source model
`timescale 1ns/1ps
module irq_poll_eoi_vector_tb_top;
	import irq_poll_pkg::*;
	localparam logic [9:0] A_VEC = {IDX_VECTOR_BASE, 2'b00};
	localparam logic [9:0] A_EOI = {IDX_EOI, 2'b00};
	localparam logic [9:0] A_ACK = {IDX_POLL_ACK, 2'b00};
	localparam logic [9:0] A_PEEK = {IDX_POLL_PEEK, 2'b00};
	localparam logic [9:0] A_ISR = {IDX_IN_SERVICE, 2'b00};
	localparam logic [9:0] A_MODE = {IDX_MODE, 2'b00};
	localparam logic [9:0] A_STAT = {IDX_IRQ_STATUS, 2'b00};
	localparam logic [9:0] A_MASK = {IDX_IRQ_MASK, 2'b00};
	logic        sys_clk, rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq_out;
	logic [9:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, irq_request, raise, drop;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	int          n_fail, comparisons;
	irq_poll_eoi_vector i_irq_poll_eoi_vector (.sys_clk, .rst_b, .irq_request, .s_axi_awvalid, .s_axi_awready,
		.s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
		.s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .irq_out);
	irq_source_model i_irq_source_model (.sys_clk, .rst_b, .raise, .drop, .irq_request);
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] e);
		@(posedge sys_clk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, e});
	endtask
	task rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF,
		input logic [1:0] r = RESP_OKAY);
		@(posedge sys_clk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
	endtask
	task src(input logic [31:0] s, input logic [31:0] d);
		@(posedge sys_clk);
		raise <= s;
		drop <= d;
		@(posedge sys_clk);
		raise <= 32'h0;
		drop <= 32'h0;
	endtask
	task end_of_test;
		$display("comparisons=%0d mismatches=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (4000) @(posedge sys_clk);
		n_fail++;
		end_of_test;
	end
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, raise, drop} = 116'h0;
		s_axi_wstrb = 4'hF;
		n_fail = 0;
		comparisons = 0;
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(A_ISR, 32'h0);
		rd(A_PEEK, 32'h0, 32'h8000);
		rd(A_ACK, 32'h0, 32'h8000);
		rd(A_ISR, 32'h0);
		rd(10'h0A0, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
		$display("reset test done");
		wr(A_MASK, 32'h1, RESP_OKAY);
		src(32'h88, 32'h0);
		rd(A_PEEK, 32'h8003);
		rd(A_PEEK, 32'h8003);
		rd(A_ACK, 32'h8003);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq_out}, 32'h1);
		rd(A_ISR, 32'h8);
		rd(A_PEEK, 32'h8007);
		rd(A_ACK, 32'h8007);
		rd(A_PEEK, 32'h0, 32'h8000);
		rd(A_STAT, 32'h1, 32'h1);
		$display("poll test done");
		wr(A_ACK, 32'h0, RESP_SLVERR);
		rd(A_ISR, 32'h88);
		rd(A_EOI, 32'h0);
		wr(A_EOI, 32'h7FE7, RESP_OKAY);
		rd(A_ISR, 32'h8);
		wr(A_EOI, 32'h8000, RESP_OKAY);
		rd(A_ISR, 32'h0);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq_out}, 32'h0);
		src(32'h0, 32'h88);
		$display("end command test done");
		wr(A_VEC, 32'hFFFF, RESP_OKAY);
		rd(A_VEC, 32'hF8);
		wr(A_MODE, 32'h1, RESP_OKAY);
		src(32'h204, 32'h0);
		rd(A_ACK, 32'h8002);
		chk({22'h0, 8'hF8 | {5'h0, s_axi_rdata[2:0]}, 2'b00}, 32'h0000_03E8);
		rd(A_ISR, 32'h4);
		rd(A_PEEK, 32'h0, 32'h8000);
		wr(A_EOI, 32'h2, RESP_OKAY);
		rd(A_ISR, 32'h0);
		$display("slave test done");
		rd(A_ACK, 32'h8002);
		@(posedge sys_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(A_ISR, 32'h0);
		rd(A_MODE, 32'h0);
		$display("midrun reset test done");
		end_of_test;
	end
endmodule
